// file: design/tef_fault_logic.sv
// transient earth-fault decision logic with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - runs only while enabled; outputs idle when off.
// - residual voltage from measured or calculated channel.
// - transient needs fundamental current at minimum threshold.
// - transient and intermittent modes are exclusive.
// - forward, reverse or any direction; direction reported.
// - transient: timer starts on transient with high voltage, rides short drops.
// - intermittent: start once peak count reaches limit.
// - intermittent: timer runs while peaks come within reset delay.
// - transient: operate when timer reaches delay with high voltage.
// - transient: drop starts reset delay; start held until it expires.
// - transient: after operate, voltage drop clears start and operate.
// - intermittent operate: count above limit, timer done, one more peak.
// - intermittent: each peak restarts reset delay; long gap resets.
// - intermittent operate is a 100 ms pulse; start ends with reset delay.
// - start progress is elapsed time as percent of operate delay.
// - directional: opposite transient raises reverse-peak block for 25 ms.
// - reverse-peak block drops when start becomes active.
// - freeze blocking holds the operate timer.
// - block-all disables the function and clears every timer.
// - block-operate runs normally but suppresses operate.
// - reset delay 40..60000 ms in 1 ms steps; peak limit 2..20, default 2.
module tef_fault_logic
   import tef_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // measurement front end
   input wire logic [15:0] meas_voltage,
   input wire logic [15:0] calc_voltage,
   input wire logic [15:0] fund_current,
   input wire logic transient_pulse,
   input wire logic transient_fwd,
   input wire logic block_in,
   // protection outputs
   output logic start_out,
   output logic operate_out,
   output logic reverse_peak_block,
   output logic [1:0] fault_dir,
   output logic [6:0] start_progress_percent
);

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam logic [6:0] PULSE_LEN = 7'(OPER_PULSE_TICKS);
   localparam logic [4:0] RBLK_LEN = 5'(REV_BLOCK_TICKS);

   typedef struct packed {
      logic ap_valid, ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      logic en, vsel, mode_tr;
      logic [1:0] dir_mode, blk_mode;
      logic [20:0] oper_dly;
      logic [15:0] rst_dly;
      logic [4:0] peak_lim;
      logic [15:0] vstart, imin, tick_cnt;
      logic tick;
      tef_state_t st;
      logic [20:0] tmr;
      logic [15:0] rcnt;
      logic [4:0] peaks;
      logic [6:0] pulse;
      logic [4:0] rblk;
      logic start, operate, rev_blk;
      logic [1:0] fdir;
      logic [6:0] pct;
   } tef_regs_t;

   tef_regs_t q;
   tef_regs_t n;

   // limit a written setting to its legal range
   function automatic logic [31:0] clamp_val(input logic [31:0] v, input logic [31:0] lo,
                                             input logic [31:0] hi);
      logic [31:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // elapsed time as a percentage, saturating at full scale
   function automatic logic [6:0] pct_of(input logic [20:0] t, input logic [20:0] d);
      logic [27:0] p;
      logic [6:0] r;
      p = 28'h0000000;
      r = PCT_FULL;
      if (d != 21'h000000 && t < d) begin
         p = ({7'h00, t} * 28'h0000064) / {7'h00, d};
         r = p[6:0];
      end
      return r;
   endfunction

   // register read mux; unmapped addresses read zero
   function automatic logic [31:0] rd_mux(input tef_regs_t s, input logic [31:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a[31:8] == 24'h000000) begin
         case (a[7:0])
            ADDR_CTRL: begin
               r[CTRL_EN_BIT] = s.en;
               r[CTRL_VSEL_BIT] = s.vsel;
               r[CTRL_MODE_BIT] = s.mode_tr;
               r[CTRL_DIR_LSB +: 2] = s.dir_mode;
               r[CTRL_BLK_LSB +: 2] = s.blk_mode;
            end
            ADDR_OPER_DLY: r[20:0] = s.oper_dly;
            ADDR_RST_DLY: r[15:0] = s.rst_dly;
            ADDR_PEAK_LIM: r[4:0] = s.peak_lim;
            ADDR_VSTART: r[15:0] = s.vstart;
            ADDR_IMIN: r[15:0] = s.imin;
            ADDR_STATUS: begin
               r[STAT_START_BIT] = s.start;
               r[STAT_OPER_BIT] = s.operate;
               r[STAT_RBLK_BIT] = s.rev_blk;
               r[STAT_FDIR_LSB +: 2] = s.fdir;
               r[STAT_PCT_LSB +: 7] = s.pct;
               r[STAT_PEAK_LSB +: 5] = s.peaks;
            end
            default: r = 32'h0000_0000;
         endcase
      end
      return r;
   endfunction

   // measurement qualification
   logic [15:0] uo;
   logic uo_hi, tr_ok, directional, dir_ok, tr_hit, tr_opp, active, freeze, op_mask, t_done, r_exp;
   logic [4:0] peaks_inc;
   logic [31:0] wcl;

   always_comb begin
      uo = q.vsel ? calc_voltage : meas_voltage;
      uo_hi = uo > q.vstart;
      tr_ok = transient_pulse && (fund_current >= q.imin);
      directional = q.dir_mode != DIR_NONDIR;
      dir_ok = !directional || ((q.dir_mode == DIR_FWD) == transient_fwd);
      tr_hit = tr_ok && dir_ok;
      tr_opp = tr_ok && directional && !dir_ok;
      active = q.en && !(block_in && q.blk_mode == BLK_ALL);
      freeze = block_in && q.blk_mode == BLK_FREEZE;
      op_mask = block_in && q.blk_mode == BLK_OPER;
      t_done = q.tmr >= q.oper_dly;
      r_exp = q.tick && ({1'b0, q.rcnt} + 17'h00001 >= {1'b0, q.rst_dly});
      peaks_inc = (q.peaks == 5'h1F) ? q.peaks : q.peaks + 5'h01;
   end

   // next state: bus, tick, fault sequence, block timer
   always_comb begin
      n = q;
      wcl = 32'h0000_0000;

      n.tick = 1'b0;
      if (q.tick_cnt >= TICK_LAST) begin
         n.tick_cnt = 16'h0000;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = q.tick_cnt + 16'h0001;
      end
      // address phase: zero wait states, so read data is fetched here
      n.ap_valid = hsel && htrans[1] && hready;
      n.ap_write = hwrite;
      n.ap_addr = haddr[31:8] == 24'h000000 ? haddr[7:0] : 8'hFF;
      n.rdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite) begin
         n.rdata = rd_mux(q, haddr);
      end
      // data phase write; out-of-range settings are clamped, not refused
      if (q.ap_valid && q.ap_write) begin
         case (q.ap_addr)
            ADDR_CTRL: begin
               n.en = hwdata[CTRL_EN_BIT];
               n.vsel = hwdata[CTRL_VSEL_BIT];
               n.mode_tr = hwdata[CTRL_MODE_BIT];
               n.dir_mode = hwdata[CTRL_DIR_LSB +: 2] == 2'h0 ? DIR_NONDIR
                                                              : hwdata[CTRL_DIR_LSB +: 2];
               n.blk_mode = hwdata[CTRL_BLK_LSB +: 2];
            end
            ADDR_OPER_DLY: begin
               wcl = clamp_val(hwdata, OPER_DLY_MIN, OPER_DLY_MAX);
               n.oper_dly = wcl[20:0];
            end
            ADDR_RST_DLY: begin
               wcl = clamp_val(hwdata, RST_DLY_MIN, RST_DLY_MAX);
               n.rst_dly = wcl[15:0];
            end
            ADDR_PEAK_LIM: begin
               wcl = clamp_val(hwdata, PEAK_LIM_MIN, PEAK_LIM_MAX);
               n.peak_lim = wcl[4:0];
            end
            ADDR_VSTART: n.vstart = hwdata[15:0];
            ADDR_IMIN: n.imin = hwdata[15:0];
            default: wcl = 32'h0000_0000;
         endcase
      end
      // reset delay and main timer advance on the tick
      if (q.tick && q.rcnt != 16'hFFFF) begin
         n.rcnt = q.rcnt + 16'h0001;
      end
      if (q.tick && !freeze && !t_done) begin
         n.tmr = q.tmr + 21'h000001;
      end
      // operate pulse runs down
      if (q.tick && q.pulse != 7'h00) begin
         n.pulse = q.pulse - 7'h01;
         if (q.pulse == 7'h01) begin
            n.operate = 1'b0;
         end
      end
      // accumulate detected direction during a fault
      if (tr_ok && (q.st != ST_IDLE || (tr_hit && uo_hi))) begin
         n.fdir = q.fdir | (transient_fwd ? FDIR_FWD : FDIR_BACK);
      end
      case (q.st)
         ST_IDLE: begin
            if (tr_hit && uo_hi) begin
               n.st = ST_RUN;
               n.tmr = 21'h000000;
               n.rcnt = 16'h0000;
               n.peaks = 5'h01;
               n.start = q.mode_tr;
            end
         end
         ST_RUN: begin
            if (q.mode_tr) begin
               if (!uo_hi) begin
                  n.st = ST_DROP;
                  n.rcnt = 16'h0000;
               // operate after the delay unless masked
               end else if (t_done && !op_mask) begin
                  n.st = ST_OPER;
                  n.operate = 1'b1;
               end
            end else if (tr_hit) begin
               // every transient restarts the reset delay
               n.rcnt = 16'h0000;
               n.peaks = peaks_inc;
               // start on reaching the peak limit
               if (peaks_inc >= q.peak_lim) begin
                  n.start = 1'b1;
               end
               // one more peak past the limit fires the pulse
               if (peaks_inc > q.peak_lim && t_done && !op_mask) begin
                  n.operate = 1'b1;
                  n.pulse = PULSE_LEN;
               end
            // a long gap ends the fault and clears the count
            end else if (r_exp) begin
               n.st = ST_IDLE;
               n.start = 1'b0;
               n.peaks = 5'h00;
               n.tmr = 21'h000000;
               n.fdir = 2'h0;
            end
         end
         ST_DROP: begin
            if (uo_hi) begin
               n.st = ST_RUN;
            // start held until reset delay runs out
            end else if (r_exp) begin
               n.st = ST_IDLE;
               n.start = 1'b0;
               n.peaks = 5'h00;
               n.tmr = 21'h000000;
               n.fdir = 2'h0;
            end
         end
         ST_OPER: begin
            // voltage drop after operate clears both at once
            if (!uo_hi) begin
               n.st = ST_IDLE;
               n.start = 1'b0;
               n.operate = 1'b0;
               n.peaks = 5'h00;
               n.tmr = 21'h000000;
               n.fdir = 2'h0;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      // a mode change mid-fault would mix the two sequences, so restart
      if (q.ap_valid && q.ap_write && q.ap_addr == ADDR_CTRL
          && hwdata[CTRL_MODE_BIT] != q.mode_tr) begin
         n.st = ST_IDLE;
         n.start = 1'b0;
         n.operate = 1'b0;
         n.pulse = 7'h00;
         n.peaks = 5'h00;
         n.tmr = 21'h000000;
      end
      // opposite-direction transient arms the block timer
      if (q.tick && q.rblk != 5'h00) begin
         n.rblk = q.rblk - 5'h01;
         if (q.rblk == 5'h01) begin
            n.rev_blk = 1'b0;
         end
      end
      if (tr_opp) begin
         n.rblk = RBLK_LEN;
         n.rev_blk = 1'b1;
      end
      // a rising start cancels the block output
      if (n.start && !q.start) begin
         n.rblk = 5'h00;
         n.rev_blk = 1'b0;
      end
      n.pct = q.start ? pct_of(q.tmr, q.oper_dly) : 7'h00;
      if (!active) begin
         n.st = ST_IDLE;
         n.tmr = 21'h000000;
         n.rcnt = 16'h0000;
         n.peaks = 5'h00;
         n.pulse = 7'h00;
         n.rblk = 5'h00;
         n.start = 1'b0;
         n.operate = 1'b0;
         n.rev_blk = 1'b0;
         n.fdir = 2'h0;
         n.pct = 7'h00;
      end
   end

   // single state register; reset clears it, then loads the setting defaults and ST_IDLE
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.en <= CTRL_RST[CTRL_EN_BIT];
         q.vsel <= CTRL_RST[CTRL_VSEL_BIT];
         q.mode_tr <= CTRL_RST[CTRL_MODE_BIT];
         q.dir_mode <= CTRL_RST[CTRL_DIR_LSB +: 2];
         q.blk_mode <= CTRL_RST[CTRL_BLK_LSB +: 2];
         q.oper_dly <= OPER_DLY_RST[20:0];
         q.rst_dly <= RST_DLY_RST[15:0];
         q.peak_lim <= PEAK_LIM_RST[4:0];
         q.vstart <= VSTART_RST;
         q.imin <= IMIN_RST;
         q.st <= ST_IDLE;
      end else begin
         q <= n;
      end
   end

   // hreadyout and hresp tied off; other outputs straight from the state register
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign start_out = q.start;
   assign operate_out = q.operate;
   assign reverse_peak_block = q.rev_blk;
   assign fault_dir = q.fdir;
   assign start_progress_percent = q.pct;

endmodule

`default_nettype wire

// file: design/tef_pkg.sv
// constants of the transient earth-fault logic
package tef_pkg;
   // clock and tick timing
   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = (TICK_US * 1000) / CLK_PERIOD_PS;
   localparam int unsigned OPER_PULSE_MS = 100;
   localparam int unsigned REV_BLOCK_MS = 25;
   localparam int unsigned OPER_PULSE_TICKS = (OPER_PULSE_MS * 1000) / TICK_US;
   localparam int unsigned REV_BLOCK_TICKS = (REV_BLOCK_MS * 1000) / TICK_US;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OPER_DLY = 8'h04;
   localparam logic [7:0] ADDR_RST_DLY = 8'h08;
   localparam logic [7:0] ADDR_PEAK_LIM = 8'h0C;
   localparam logic [7:0] ADDR_VSTART = 8'h10;
   localparam logic [7:0] ADDR_IMIN = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // control register fields
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_VSEL_BIT = 1;
   localparam int unsigned CTRL_MODE_BIT = 2;
   localparam int unsigned CTRL_DIR_LSB = 4;
   localparam int unsigned CTRL_BLK_LSB = 8;
   // status register fields
   localparam int unsigned STAT_START_BIT = 0;
   localparam int unsigned STAT_OPER_BIT = 1;
   localparam int unsigned STAT_RBLK_BIT = 2;
   localparam int unsigned STAT_FDIR_LSB = 4;
   localparam int unsigned STAT_PCT_LSB = 8;
   localparam int unsigned STAT_PEAK_LSB = 16;
   // reset values and setting ranges
   localparam logic [31:0] CTRL_RST = 32'h0000_0021;
   localparam logic [31:0] OPER_DLY_RST = 32'h0000_01F4;
   localparam logic [31:0] OPER_DLY_MIN = 32'h0000_0028;
   localparam logic [31:0] OPER_DLY_MAX = 32'h0012_4F80;
   localparam logic [31:0] RST_DLY_RST = 32'h0000_01F4;
   localparam logic [31:0] RST_DLY_MIN = 32'h0000_0028;
   localparam logic [31:0] RST_DLY_MAX = 32'h0000_EA60;
   localparam logic [31:0] PEAK_LIM_RST = 32'h0000_0002;
   localparam logic [31:0] PEAK_LIM_MIN = 32'h0000_0002;
   localparam logic [31:0] PEAK_LIM_MAX = 32'h0000_0014;
   localparam logic [15:0] VSTART_RST = 16'h00C8;
   localparam logic [15:0] IMIN_RST = 16'h000A;
   localparam logic [6:0] PCT_FULL = 7'h64;
   // directional, blocking and fault direction codes
   localparam logic [1:0] DIR_NONDIR = 2'h1;
   localparam logic [1:0] DIR_FWD = 2'h2;
   localparam logic [1:0] DIR_REV = 2'h3;
   localparam logic [1:0] BLK_NONE = 2'h0;
   localparam logic [1:0] BLK_FREEZE = 2'h1;
   localparam logic [1:0] BLK_ALL = 2'h2;
   localparam logic [1:0] BLK_OPER = 2'h3;
   localparam logic [1:0] FDIR_FWD = 2'h1;
   localparam logic [1:0] FDIR_BACK = 2'h2;
   // fault sequence states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN = 4'h2,
      ST_DROP = 4'h4,
      ST_OPER = 4'h8
   } tef_state_t;
endpackage

// file: sim/tef_fault_logic_assertions.sv
// port-level assertion checker of the transient earth-fault logic
`timescale 1ns/1ps
`default_nettype none
module tef_fault_chk
   import tef_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // measurements and protection outputs
   input wire logic transient_pulse,
   input wire logic start_out,
   input wire logic operate_out,
   input wire logic reverse_peak_block,
   input wire logic [6:0] start_progress_percent
);
   logic rd_taken;
   logic [31:0] gap_r;
   // cycles since the last transient
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_r <= 32'h0000_0000;
      end else begin
         gap_r <= transient_pulse ? 32'h0000_0000 : gap_r + 32'h0000_0001;
      end
   end
   assign rd_taken = hsel && htrans[1] && hready && !hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // read data only in a read's data phase
   a_rdata_idle: assert property (!rd_taken |=> hrdata == 32'h0000_0000)
      else $error("read data outside a data phase");
   a_start_cause: assert property ($rose(start_out) |-> $past(transient_pulse))
      else $error("start rose without a transient");
   a_rblk_cause: assert property ($rose(reverse_peak_block) |-> $past(transient_pulse))
      else $error("reverse block rose without a transient");
   a_rblk_len: assert property (reverse_peak_block |-> gap_r <= 26 * TICK_CYCLES)
      else $error("reverse block held too long");
   a_start_clr_rblk: assert property ($rose(start_out) |-> ##[0:1] !reverse_peak_block)
      else $error("reverse block kept after start");
   a_pct_range: assert property (start_progress_percent <= PCT_FULL)
      else $error("progress above full scale");
   a_oper_full: assert property ($rose(operate_out) |-> ##[0:1] start_progress_percent == PCT_FULL)
      else $error("operate before full progress");
   a_oper_start: assert property ($rose(operate_out) |-> $past(start_out))
      else $error("operate without start");
   c_start: cover property ($rose(start_out));
   c_oper: cover property ($rose(operate_out));
   c_rblk: cover property ($rose(reverse_peak_block));
endmodule
bind tef_fault_logic tef_fault_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .transient_pulse(transient_pulse),
   .start_out(start_out), .operate_out(operate_out), .reverse_peak_block(reverse_peak_block),
   .start_progress_percent(start_progress_percent)
);
`default_nettype wire

// file: sim/tef_front_end.sv
// measurement front end model driving residual levels and transient pulses
`timescale 1ns/1ps
`default_nettype none
module tef_front_end (
   // clock
   input wire logic hclk,
   // measurements towards the block
   output logic [15:0] meas_voltage,
   output logic [15:0] calc_voltage,
   output logic [15:0] fund_current,
   output logic transient_pulse,
   output logic transient_fwd
);
   // quiet lines at time zero
   initial begin
      meas_voltage = 16'h0000;
      calc_voltage = 16'h0000;
      fund_current = 16'h0000;
      transient_pulse = 1'b0;
      transient_fwd = 1'b0;
   end
   // levels change just after an edge
   task automatic set_lvl(input logic [15:0] m, input logic [15:0] c, input logic [15:0] i);
      @(posedge hclk);
      meas_voltage <= m;
      calc_voltage <= c;
      fund_current <= i;
   endtask
   // one high cycle; direction then flips
   task automatic peak(input logic fwd);
      @(posedge hclk);
      transient_pulse <= 1'b1;
      transient_fwd <= fwd;
      @(posedge hclk);
      transient_pulse <= 1'b0;
      transient_fwd <= ~fwd;
   endtask
endmodule
`default_nettype wire

// file: sim/tef_fault_logic_tb.sv
// self-checking bench of the transient earth-fault logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("FAIL %0t got %0h expected %0h", $time, (got), (exp)); end end
module tef_fault_logic_tb
   import tef_pkg::*;
;
   localparam int unsigned TK = 20;
   localparam int LIMIT = 40000;
   localparam logic [15:0] HI = 16'h012C;
   localparam logic [15:0] LO = 16'h0000;
   localparam logic [15:0] IOK = 16'h0064;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, block_in;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, fault_dir;
   logic [2:0] hsize;
   logic [15:0] meas_voltage, calc_voltage, fund_current;
   logic transient_pulse, transient_fwd, start_out, operate_out, reverse_peak_block;
   logic [6:0] start_progress_percent;
   int miscompares, cmp_count, cyc;
   logic [7:0] ra [8] = '{ADDR_CTRL, ADDR_OPER_DLY, ADDR_RST_DLY, ADDR_PEAK_LIM, ADDR_VSTART,
      ADDR_IMIN, ADDR_STATUS, 8'h40};
   logic [31:0] rv [8] = '{CTRL_RST, OPER_DLY_RST, RST_DLY_RST, PEAK_LIM_RST,
      {16'h0000, VSTART_RST}, {16'h0000, IMIN_RST}, 32'h0000_0000, 32'h0000_0000};
   tef_fault_logic #(.TICK_CYCLES(TK)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_voltage(meas_voltage),
      .calc_voltage(calc_voltage), .fund_current(fund_current),
      .transient_pulse(transient_pulse), .transient_fwd(transient_fwd), .block_in(block_in),
      .start_out(start_out), .operate_out(operate_out),
      .reverse_peak_block(reverse_peak_block), .fault_dir(fault_dir),
      .start_progress_percent(start_progress_percent)
   );
   tef_front_end u_fe (
      .hclk(hclk), .meas_voltage(meas_voltage), .calc_voltage(calc_voltage),
      .fund_current(fund_current), .transient_pulse(transient_pulse),
      .transient_fwd(transient_fwd)
   );
   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic stop_test();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         miscompares++;
         stop_test();
      end
   end
   // #1: let the edge's updates land
   task automatic wait_cyc(input int unsigned n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // one transfer: address phase, then data phase, each until ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, rd);
      `CHK(rd, exp)
   endtask
   function automatic logic [31:0] ctl(input logic vsel, input logic mode,
                                       input logic [1:0] dir, input logic [1:0] blk);
      return {22'h0, blk, 2'h0, dir, 1'b0, mode, vsel, 1'b1};
   endfunction
   // a transient, then one cycle for the registered outputs
   task automatic hit(input logic fwd);
      u_fe.peak(fwd);
      wait_cyc(1);
   endtask
   task automatic blk(input logic v);
      @(posedge hclk);
      block_in <= v;
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      block_in = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped word, clamping, read-only status
      for (int k = 0; k < 8; k++) begin
         rdchk(ra[k], rv[k]);
      end
      wr(ADDR_PEAK_LIM, 32'h0000_0019);
      rdchk(ADDR_PEAK_LIM, PEAK_LIM_MAX);
      wr(ADDR_RST_DLY, 32'h0000_000A);
      rdchk(ADDR_RST_DLY, RST_DLY_MIN);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rdchk(ADDR_STATUS, 32'h0000_0000);
      wr(ADDR_OPER_DLY, 32'h0000_0028);
      wr(ADDR_PEAK_LIM, 32'h0000_0002);
      // switched off: all quiet
      wr(ADDR_CTRL, 32'h0000_0014);
      u_fe.set_lvl(HI, HI, IOK);
      hit(1'b1);
      rdchk(ADDR_STATUS, 32'h0000_0000);
      // transient: weak current, start, progress, operate, clear
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_NONDIR, BLK_NONE));
      u_fe.set_lvl(HI, LO, 16'h0005);
      hit(1'b1);
      `CHK(start_out, 1'b0)
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      `CHK(start_out, 1'b1)
      wait_cyc(30 * TK);
      `CHK(start_progress_percent inside {[7'h46:7'h50]}, 1'b1)
      `CHK(operate_out, 1'b0)
      wait_cyc(12 * TK);
      `CHK(operate_out, 1'b1)
      u_fe.set_lvl(LO, LO, IOK);
      wait_cyc(2);
      `CHK({start_out, operate_out}, 2'b00)
      // short drop keeps the timer; long drop ends start
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      wait_cyc(5 * TK);
      u_fe.set_lvl(LO, LO, IOK);
      wait_cyc(20 * TK);
      u_fe.set_lvl(HI, LO, IOK);
      wait_cyc(20 * TK);
      `CHK(operate_out, 1'b1)
      u_fe.set_lvl(LO, LO, IOK);
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      wait_cyc(10 * TK);
      u_fe.set_lvl(LO, LO, IOK);
      wait_cyc(35 * TK);
      `CHK({start_out, operate_out}, 2'b10)
      wait_cyc(8 * TK);
      `CHK(start_out, 1'b0)
      // freeze holds the timer while blocked
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_NONDIR, BLK_FREEZE));
      blk(1'b1);
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      wait_cyc(60 * TK);
      `CHK(operate_out, 1'b0)
      blk(1'b0);
      wait_cyc(45 * TK);
      `CHK(operate_out, 1'b1)
      u_fe.set_lvl(LO, LO, IOK);
      // block-operate runs but never operates; block-all clears it all
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_NONDIR, BLK_OPER));
      blk(1'b1);
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      wait_cyc(50 * TK);
      `CHK({start_out, operate_out}, 2'b10)
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_NONDIR, BLK_ALL));
      wait_cyc(3);
      `CHK({start_out, start_progress_percent}, 8'h00)
      u_fe.set_lvl(LO, LO, IOK);
      blk(1'b0);
      // intermittent: peaks, operate pulse, long gap
      wr(ADDR_CTRL, ctl(1'b0, 1'b0, DIR_NONDIR, BLK_NONE));
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      `CHK(start_out, 1'b0)
      repeat (3) begin
         wait_cyc(10 * TK);
         hit(1'b1);
      end
      `CHK({start_out, operate_out}, 2'b10)
      wait_cyc(15 * TK);
      hit(1'b1);
      `CHK(operate_out, 1'b1)
      wait_cyc(35 * TK);
      `CHK(start_out, 1'b1)
      wait_cyc(61 * TK);
      `CHK({start_out, operate_out}, 2'b01)
      wait_cyc(5 * TK);
      rdchk(ADDR_STATUS, 32'h0000_0000);
      hit(1'b1);
      wait_cyc(45 * TK);
      hit(1'b1);
      `CHK(start_out, 1'b0)
      wait_cyc(45 * TK);
      // forward only: reverse peak blocks, start unblocks
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_FWD, BLK_NONE));
      hit(1'b0);
      `CHK({start_out, reverse_peak_block}, 2'b01)
      wait_cyc(22 * TK);
      `CHK(reverse_peak_block, 1'b1)
      wait_cyc(4 * TK);
      `CHK(reverse_peak_block, 1'b0)
      hit(1'b0);
      hit(1'b1);
      `CHK({start_out, reverse_peak_block, fault_dir[0]}, 3'b101)
      u_fe.set_lvl(LO, LO, IOK);
      wait_cyc(45 * TK);
      // reverse only: forward feeds the block, reverse starts
      wr(ADDR_CTRL, ctl(1'b0, 1'b1, DIR_REV, BLK_NONE));
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      `CHK({start_out, reverse_peak_block}, 2'b01)
      hit(1'b0);
      `CHK(start_out, 1'b1)
      u_fe.set_lvl(LO, LO, IOK);
      wait_cyc(45 * TK);
      // calculated source, threshold under the phase-to-phase limit
      wr(ADDR_VSTART, 32'h0000_00C8);
      wr(ADDR_CTRL, ctl(1'b1, 1'b1, DIR_NONDIR, BLK_NONE));
      u_fe.set_lvl(HI, LO, IOK);
      hit(1'b1);
      `CHK(start_out, 1'b0)
      u_fe.set_lvl(LO, HI, IOK);
      hit(1'b1);
      `CHK(start_out, 1'b1)
      stop_test();
   end
endmodule
`default_nettype wire
